// File: logic/ilu_defines.svh
// register offsets, field positions, reset values and queue depth of the interrupt log unit
`ifndef ILU_DEFINES_SVH
`define ILU_DEFINES_SVH

// register byte offsets
`define ILU_CTRL_OFS      12'h000
`define ILU_STD_EN_OFS    12'h004
`define ILU_HP_EN_OFS     12'h008
`define ILU_HP_STAT_OFS   12'h00C
`define ILU_LOG_ADDR_OFS  12'h010
`define ILU_PEND_OFS      12'h014

// interrupt status word fields
`define ILU_BIT_ACCESSED  15
`define ILU_BIT_TIMEOUT   14
`define ILU_BIT_RT_ME     13
`define ILU_BIT_SA_EVT    7
`define ILU_BIT_MC_NODATA 6
`define ILU_BIT_ILL_BCST  5
`define ILU_BIT_ILL_CMD   4
`define ILU_BIT_POLL      3
`define ILU_BIT_RETRY     2
`define ILU_BIT_MSG_ERR   1
`define ILU_BIT_INT_CONT  0
`define ILU_EVT_MASK      16'h60FF

// high-priority status bits
`define ILU_HP_STD_BIT    8
`define ILU_HP_WIDTH      9

// control register bits
`define ILU_CTRL_RT_MODE  0
`define ILU_CTRL_STDL_EN  1

// reset values
`define ILU_LOG_ADDR_RST  16'h0000
`define ILU_EN_RST        16'h0000

// pending queue depth
`define ILU_QDEPTH        4
`define ILU_QPTR_W        2

`endif

// File: logic/ilu_pkg.sv
// types shared by the interrupt log unit files
package ilu_pkg;

  // one captured event, queued until it is logged
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] pointer;
  } ilu_event_s;

  // memory request toward the dma port
  typedef struct packed {
    logic        req;
    logic        burst;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ilu_dma_req_s;

  // dma answer
  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } ilu_dma_rsp_s;

  // record writer states, one-hot
  typedef enum logic [4:0] {
    ILU_IDLE  = 5'b00001,
    ILU_ARB   = 5'b00010,
    ILU_WSTAT = 5'b00100,
    ILU_WPTR  = 5'b01000,
    ILU_RLINK = 5'b10000
  } ilu_state_e;

endpackage

// File: logic/ilu_event_queue.sv
// small flip-flop queue of pending log events
`timescale 1ns/1ps
`include "ilu_defines.svh"

module ilu_event_queue (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // filling side
  input  wire logic                in_valid,
  output wire logic                in_ready,
  input  wire ilu_pkg::ilu_event_s in_data,
  // draining side
  output wire logic                out_valid,
  input  wire logic                out_ready,
  output wire ilu_pkg::ilu_event_s out_data,
  // fill level
  output wire logic [2:0]          count
);
  import ilu_pkg::*;

  ilu_event_s                  store [`ILU_QDEPTH];
  logic [`ILU_QPTR_W-1:0]      wr_ptr;
  logic [`ILU_QPTR_W-1:0]      rd_ptr;
  logic [2:0]                  level;

  // handshake decode
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (level != 3'(`ILU_QDEPTH));
  assign out_valid = (level != 3'd0);
  assign out_data  = store[rd_ptr];
  assign count     = level;

  // pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= 3'd0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      level <= level + 3'(push) - 3'(pop);
    end
  end

  // storage entries, one per slot
  genvar gi;
  generate
    for (gi = 0; gi < `ILU_QDEPTH; gi++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          store[gi] <= '0;
        end else if (push && wr_ptr == `ILU_QPTR_W'(gi)) begin
          store[gi] <= in_data;
        end
      end
    end
  endgenerate

endmodule

// File: logic/ilu_apb_regs.sv
// apb slave with the control, enable, status and log address registers
`timescale 1ns/1ps
`include "ilu_defines.svh"

module ilu_apb_regs (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // register values
  output logic      [15:0] ctrl,
  output logic      [15:0] std_en,
  output logic      [15:0] hp_en,
  // status and log address read back
  input  wire logic [8:0]  hp_status,
  input  wire logic [15:0] log_addr,
  input  wire logic [2:0]  pend_count,
  // write strobes decoded for the core
  output wire logic        hp_clr_we,
  output wire logic        log_addr_we,
  output wire logic [15:0] wdata
);
  // address decode
  wire acc       = psel && penable;
  wire wr        = acc && pwrite;
  wire hit_ctrl  = (paddr == `ILU_CTRL_OFS);
  wire hit_std   = (paddr == `ILU_STD_EN_OFS);
  wire hit_hp    = (paddr == `ILU_HP_EN_OFS);
  wire hit_stat  = (paddr == `ILU_HP_STAT_OFS);
  wire hit_log   = (paddr == `ILU_LOG_ADDR_OFS);
  wire hit_pend  = (paddr == `ILU_PEND_OFS);
  wire mapped    = hit_ctrl | hit_std | hit_hp | hit_stat | hit_log | hit_pend;

  // zero wait states; unmapped offsets answer with an error
  assign pready      = 1'b1;
  assign pslverr     = acc && !mapped;
  assign hp_clr_we   = wr && hit_stat;
  assign log_addr_we = wr && hit_log;
  assign wdata       = pwdata[15:0];

  // read mux, upper bits read as zero
  wire [15:0] rmux = hit_ctrl ? ctrl :
                     hit_std  ? std_en :
                     hit_hp   ? hp_en :
                     hit_stat ? {7'd0, hp_status} :
                     hit_log  ? log_addr :
                     hit_pend ? {13'd0, pend_count} : 16'h0000;

  // software-owned registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= `ILU_EN_RST;
      std_en <= `ILU_EN_RST;
      hp_en  <= `ILU_EN_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl <= pwdata[15:0];
      if (hit_std) std_en <= pwdata[15:0] & `ILU_EVT_MASK;
      if (hit_hp) hp_en <= pwdata[15:0] & `ILU_EVT_MASK;
    end
  end

  // registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rmux};
    end
  end

endmodule

// File: logic/ilu_top.sv
// exception handling and interrupt logging unit: interrupt outputs and log list writer
`timescale 1ns/1ps
`include "ilu_defines.svh"

module ilu_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb register port
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output wire logic [31:0]           prdata,
  output wire logic                  pready,
  output wire logic                  pslverr,
  // event sources from the message engine, taken while evt_valid and evt_ready are both high
  input  wire logic                  evt_valid,
  input  wire logic                  evt_resp_timeout,
  input  wire logic                  evt_status_me,
  input  wire logic                  evt_sa_irq,
  input  wire logic                  evt_mc_nodata,
  input  wire logic                  evt_ill_bcst,
  input  wire logic                  evt_ill_cmd,
  input  wire logic                  evt_poll_match,
  input  wire logic                  evt_retry_fail,
  input  wire logic                  evt_msg_error,
  input  wire logic                  evt_int_cont,
  input  wire logic [15:0]           evt_pointer,
  output wire logic                  evt_ready,
  // dma port to system memory
  output ilu_pkg::ilu_dma_req_s      dma_req,
  input  wire ilu_pkg::ilu_dma_rsp_s dma_rsp,
  // interrupt outputs
  output logic                       std_irq_level_out,
  output logic                       std_irq_pulse,
  output logic                       high_prio_irq,
  output wire logic                  bc_hold
);
  import ilu_pkg::*;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0] ctrl;
  logic [15:0] std_en;
  logic [15:0] hp_en;
  logic [8:0]  hp_status;
  logic [15:0] log_addr;
  logic [2:0]  pend_count;
  logic        hp_clr_we;
  logic        log_addr_we;
  logic [15:0] wdata;

  ilu_apb_regs u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .ctrl        (ctrl),
    .std_en      (std_en),
    .hp_en       (hp_en),
    .hp_status   (hp_status),
    .log_addr    (log_addr),
    .pend_count  (pend_count),
    .hp_clr_we   (hp_clr_we),
    .log_addr_we (log_addr_we),
    .wdata       (wdata)
  );

  // ****************************************************************
  // event word assembly
  // ****************************************************************
  wire rt_mode = ctrl[`ILU_CTRL_RT_MODE];

  // mode-specific causes only count in their own mode; reserved bits stay zero
  logic [15:0] raw_word;
  always_comb begin
    raw_word = 16'h0000;
    raw_word[`ILU_BIT_TIMEOUT]   = evt_resp_timeout && evt_msg_error;
    raw_word[`ILU_BIT_RT_ME]     = evt_status_me;
    raw_word[`ILU_BIT_SA_EVT]    = rt_mode && evt_sa_irq;
    raw_word[`ILU_BIT_MC_NODATA] = rt_mode && evt_mc_nodata;
    raw_word[`ILU_BIT_ILL_BCST]  = rt_mode && evt_ill_bcst;
    raw_word[`ILU_BIT_ILL_CMD]   = rt_mode && evt_ill_cmd;
    raw_word[`ILU_BIT_POLL]      = !rt_mode && evt_poll_match;
    raw_word[`ILU_BIT_RETRY]     = !rt_mode && evt_retry_fail;
    raw_word[`ILU_BIT_MSG_ERR]   = evt_msg_error;
    raw_word[`ILU_BIT_INT_CONT]  = !rt_mode && evt_int_cont;
  end

  // only enabled causes make a record or raise an output
  wire [15:0] std_hits = raw_word & std_en & `ILU_EVT_MASK;
  wire [15:0] hp_hits  = raw_word & hp_en & `ILU_EVT_MASK;
  wire        std_evt  = evt_valid && evt_ready && (std_hits != 16'h0000);
  wire        hp_evt   = evt_valid && evt_ready && (hp_hits != 16'h0000);
  wire        hp_me    = hp_evt && hp_hits[`ILU_BIT_MSG_ERR];

  // ****************************************************************
  // pending event queue
  // ****************************************************************
  ilu_event_s q_in;
  ilu_event_s q_out;
  logic       q_in_ready;
  logic       q_out_valid;
  logic       q_pop;

  // second word: command block or descriptor address from the engine
  assign q_in.status  = std_hits;
  assign q_in.pointer = evt_pointer;
  // a full queue stalls the engine so no enabled event is dropped
  assign evt_ready    = q_in_ready;

  ilu_event_queue u_queue (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (std_evt),
    .in_ready  (q_in_ready),
    .in_data   (q_in),
    .out_valid (q_out_valid),
    .out_ready (q_pop),
    .out_data  (q_out),
    .count     (pend_count)
  );

  // ****************************************************************
  // record writer
  // ****************************************************************
  ilu_state_e  state;
  ilu_state_e  next_state;
  ilu_event_s  cur;
  logic [15:0] rec_base;

  // one record at a time; the next event waits in the queue
  always_comb begin
    case (state)
      ILU_IDLE:  next_state = q_out_valid ? ILU_ARB : ILU_IDLE;
      ILU_ARB:   next_state = ILU_WSTAT;
      ILU_WSTAT: next_state = dma_rsp.done ? ILU_WPTR : ILU_WSTAT;
      ILU_WPTR:  next_state = dma_rsp.done ? ILU_RLINK : ILU_WPTR;
      ILU_RLINK: next_state = dma_rsp.done ? ILU_IDLE : ILU_RLINK;
      default:   next_state = ILU_IDLE;
    endcase
  end

  assign q_pop = (state == ILU_IDLE) && q_out_valid;

  // dma request decode; burst held across the whole record
  assign dma_req.req   = (state == ILU_WSTAT) || (state == ILU_WPTR) || (state == ILU_RLINK);
  assign dma_req.burst = (state != ILU_IDLE);
  assign dma_req.write = (state == ILU_WSTAT) || (state == ILU_WPTR);
  assign dma_req.addr  = (state == ILU_WPTR)  ? rec_base + 16'h0001 :
                         (state == ILU_RLINK) ? rec_base + 16'h0002 : rec_base;
  // accessed flag always set in the stored word
  assign dma_req.wdata = (state == ILU_WPTR) ? cur.pointer :
                         (cur.status | (16'h0001 << `ILU_BIT_ACCESSED));

  wire rec_done = (state == ILU_RLINK) && dma_rsp.done;

  // state and current record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ILU_IDLE;
      cur      <= '0;
      rec_base <= `ILU_LOG_ADDR_RST;
    end else begin
      state <= next_state;
      if (q_pop) begin
        cur      <= q_out;
        rec_base <= log_addr;
      end
    end
  end

  // log address: host sets the start, hardware loads the link word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_addr <= `ILU_LOG_ADDR_RST;
    end else if (rec_done) begin
      log_addr <= dma_rsp.rdata;
    end else if (log_addr_we) begin
      log_addr <= wdata;
    end
  end

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************
  // per-cause high-priority status; a new cause wins over a clear
  wire [8:0] hp_set = {1'b0, hp_hits[7:0]};
  wire [8:0] hp_clr = hp_clr_we ? wdata[8:0] : 9'h000;
  wire       std_set = rec_done;

  logic [8:0] next_hp_status;
  always_comb begin
    next_hp_status = (hp_status & ~hp_clr) | (hp_evt ? hp_set : 9'h000);
    if (std_set) begin
      next_hp_status[`ILU_HP_STD_BIT] = 1'b1;
    end
  end

  // standard bit also raises the level; hold follows an unacknowledged error
  logic hold_me;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_status <= 9'h000;
      hold_me   <= 1'b0;
    end else begin
      hp_status <= next_hp_status;
      if (hp_me) begin
        hold_me <= 1'b1;
      end else if (hp_clr_we && wdata[`ILU_BIT_MSG_ERR]) begin
        hold_me <= 1'b0;
      end
    end
  end

  // controller holds only in controller mode
  assign bc_hold = hold_me && !rt_mode;

  // outputs from flops; pulse after the link read ends the record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_irq_pulse     <= 1'b0;
      std_irq_level_out <= 1'b0;
      high_prio_irq     <= 1'b0;
    end else begin
      std_irq_pulse     <= rec_done;
      std_irq_level_out <= next_hp_status[`ILU_HP_STD_BIT] && ctrl[`ILU_CTRL_STDL_EN];
      high_prio_irq     <= (next_hp_status[7:0] != 8'h00);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_stat_write;
    @(posedge pclk) disable iff (!presetn)
    (state == ILU_WSTAT) |-> dma_req.write && dma_req.wdata[15] && dma_req.wdata[12:8] == 5'd0;
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("status word wrong");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
    (state == ILU_WSTAT && dma_rsp.done) |=> (state == ILU_WPTR) && dma_req.addr == rec_base + 16'h0001;
  endproperty
  a_order: assert property (p_order) else $error("pointer write out of order");

  property p_link;
    @(posedge pclk) disable iff (!presetn)
    rec_done |=> log_addr == $past(dma_rsp.rdata);
  endproperty
  a_link: assert property (p_link) else $error("log address not advanced");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    rec_done |=> std_irq_pulse ##1 !std_irq_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse missing");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
    (rec_done && ctrl[`ILU_CTRL_STDL_EN]) |=> std_irq_level_out;
  endproperty
  a_level: assert property (p_level) else $error("level not raised");

  property p_hp_hold;
    @(posedge pclk) disable iff (!presetn)
    (high_prio_irq && !hp_clr_we) |=> high_prio_irq;
  endproperty
  a_hp_hold: assert property (p_hp_hold) else $error("hp dropped without write");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (hp_clr_we && wdata[`ILU_BIT_MSG_ERR] && !hp_evt) |=> !hp_status[`ILU_BIT_MSG_ERR];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear");

  property p_one_rec;
    @(posedge pclk) disable iff (!presetn)
    q_pop |=> !q_pop [*3];
  endproperty
  a_one_rec: assert property (p_one_rec) else $error("record overlap");

  property p_hp_raise;
    @(posedge pclk) disable iff (!presetn)
    (hp_evt && hp_hits[7:0] != 8'h00) |=> high_prio_irq;
  endproperty
  a_hp_raise: assert property (p_hp_raise) else $error("hp not raised");

  property p_level_hold;
    @(posedge pclk) disable iff (!presetn)
    (std_irq_level_out && ctrl[`ILU_CTRL_STDL_EN] && !(hp_clr_we && wdata[`ILU_HP_STD_BIT])) |=> std_irq_level_out;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level dropped without clear");

  property p_cpu_log;
    @(posedge pclk) disable iff (!presetn)
    (log_addr_we && !rec_done) |=> (log_addr == $past(wdata));
  endproperty
  a_cpu_log: assert property (p_cpu_log) else $error("log address write lost");

  property p_pulse_src;
    @(posedge pclk) disable iff (!presetn)
    std_irq_pulse |-> $past(rec_done);
  endproperty
  a_pulse_src: assert property (p_pulse_src) else $error("pulse without record");

  property p_link_read;
    @(posedge pclk) disable iff (!presetn)
    (state == ILU_RLINK) |-> dma_req.req && dma_req.burst && !dma_req.write && (dma_req.addr == rec_base + 16'h0002);
  endproperty
  a_link_read: assert property (p_link_read) else $error("link read wrong");

endmodule

// File: verification/ilu_mem_model.sv
// memory model on the dma port of the log unit
`timescale 1ns/1ps
module ilu_mem_model (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // dma port
  input  wire ilu_pkg::ilu_dma_req_s dma_req,
  output ilu_pkg::ilu_dma_rsp_s      dma_rsp,
  // wait cycles before each answer
  input  wire logic [3:0]            lat
);
  import ilu_pkg::*;
  logic [15:0] mem [256];
  logic [3:0]  wait_cnt;
  // one word per request; plain always so the bench can preload links
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rsp <= '0;
      wait_cnt <= '0;
    end else if (dma_rsp.done) begin
      // done stands one cycle, then data flips so stale words never match
      dma_rsp.done <= 1'b0;
      dma_rsp.rdata <= ~dma_rsp.rdata;
      wait_cnt <= '0;
    end else if (dma_req.req && wait_cnt == lat) begin
      dma_rsp.done <= 1'b1;
      if (dma_req.write) begin
        mem[dma_req.addr[7:0]] <= dma_req.wdata;
      end else begin
        dma_rsp.rdata <= mem[dma_req.addr[7:0]];
      end
    end else if (dma_req.req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// File: verification/interrupt_log_unit_test.sv
// self-checking bench of the interrupt log unit
`timescale 1ns/1ps
`include "ilu_defines.svh"
module interrupt_log_unit_test;
  import ilu_pkg::*;
  // ****************
  // signals
  // ****************
  logic          pclk = 0;
  logic          presetn = 0;
  logic          psel = 0;
  logic          penable = 0;
  logic          pwrite = 0;
  logic [11:0]   paddr = 0;
  logic [31:0]   pwdata = 0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, er;
  logic          evt_valid = 0;
  logic [9:0]    cause = 0;
  logic [15:0]   evt_pointer = 0;
  logic [15:0]   base = 16'h0010;
  logic [3:0]    lat = 0;
  logic          evt_ready, std_irq_level_out, std_irq_pulse, high_prio_irq, bc_hold;
  ilu_dma_req_s  dma_req;
  ilu_dma_rsp_s  dma_rsp;
  int            bad_count = 0;
  int            n_compared = 0;
  int            pulses = 0;
  int            npulse = 0;
  logic [10:0]   tbl [10] = '{11'h202, 11'h008, 11'h004, 11'h002, 11'h001,
                              11'h500, 11'h480, 11'h440, 11'h420, 11'h410};
  // clock and pulse counter kept apart from the tasks
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (std_irq_pulse === 1'b1) pulses <= pulses + 1;
  ilu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_valid(evt_valid), .evt_resp_timeout(cause[9]), .evt_status_me(cause[8]),
    .evt_sa_irq(cause[7]), .evt_mc_nodata(cause[6]), .evt_ill_bcst(cause[5]), .evt_ill_cmd(cause[4]),
    .evt_poll_match(cause[3]), .evt_retry_fail(cause[2]), .evt_msg_error(cause[1]),
    .evt_int_cont(cause[0]), .evt_pointer(evt_pointer), .evt_ready(evt_ready), .dma_req(dma_req),
    .dma_rsp(dma_rsp), .std_irq_level_out(std_irq_level_out), .std_irq_pulse(std_irq_pulse),
    .high_prio_irq(high_prio_irq), .bc_hold(bc_hold));
  ilu_mem_model mem (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .dma_rsp(dma_rsp), .lat(lat));
  // ****************
  // helpers
  // ****************
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer, request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // event held until the queue takes it; caller lowers valid
  task automatic fire(input logic [9:0] c, input logic [15:0] p);
    int i;
    evt_valid <= 1'b1;
    cause <= c;
    evt_pointer <= p;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (evt_ready !== 1'b1 && i < 50);
    if (evt_ready !== 1'b1) begin
      bad_count++;
      end_of_test;
    end
  endtask
  // bounded wait, then a quiet spell so extra pulses show up
  task automatic wait_pulses;
    int i;
    for (i = 0; i < 3000 && pulses != npulse; i++) @(negedge pclk);
    if (i >= 3000) begin
      bad_count++;
      end_of_test;
    end
    repeat (20) @(negedge pclk);
    chk(pulses, npulse);
  endtask
  task automatic rec(input logic [9:0] c, input logic [15:0] p, input logic [15:0] nxt);
    mem.mem[base[7:0] + 8'h02] = nxt;
    fire(c, p);
    evt_valid <= 1'b0;
    npulse++;
    wait_pulses;
    chk(mem.mem[base[7:0]], {1'b1, c[9:8], 5'h00, c[7:0]});
    chk(mem.mem[base[7:0] + 8'h01], p);
    apb(1'b0, `ILU_LOG_ADDR_OFS, 0);
    chk(rd, nxt);
    base = nxt;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    int i;
    chk({std_irq_level_out, std_irq_pulse, high_prio_irq, bc_hold, evt_ready, dma_req.req}, 6'h02);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 0);
      chk({er, rd}, 0);
    end
    apb(1'b0, 12'h018, 32'hFFFF_FFFF);
    chk({er, rd}, 33'h1_0000_0000);
    apb(1'b1, `ILU_LOG_ADDR_OFS, 32'h0000_0010);
    apb(1'b0, `ILU_LOG_ADDR_OFS, 0);
    chk(rd, 32'h0000_0010);
  endtask
  task automatic t_one;
    apb(1'b1, `ILU_CTRL_OFS, 32'h0000_0002);
    apb(1'b1, `ILU_STD_EN_OFS, 32'h0000_0008);
    rec(10'h008, 16'h1234, 16'h0040);
    chk({std_irq_level_out, high_prio_irq}, 2'h2);
    apb(1'b0, `ILU_HP_STAT_OFS, 0);
    chk(rd, 32'h0000_0100);
    apb(1'b1, `ILU_HP_STAT_OFS, 32'h0000_0100);
    @(negedge pclk);
    chk(std_irq_level_out, 0);
  endtask
  // a cause that is disabled or belongs to the other mode leaves no record
  task automatic t_masked(input logic [9:0] c);
    mem.mem[base[7:0]] = 16'h0000;
    fire(c, 16'h5555);
    evt_valid <= 1'b0;
    wait_pulses;
    chk(mem.mem[base[7:0]], 0);
  endtask
  task automatic t_causes;
    int i;
    apb(1'b1, `ILU_STD_EN_OFS, 32'h0000_60FF);
    for (i = 0; i < 10; i++) begin
      apb(1'b1, `ILU_CTRL_OFS, {31'h0, tbl[i][10]});
      rec(tbl[i][9:0], 16'h0300 + 16'(i), base + 16'h0010);
    end
  endtask
  task automatic t_burst;
    apb(1'b1, `ILU_CTRL_OFS, 0);
    lat <= 4'h3;
    mem.mem[8'hE2] = 16'h0008;
    mem.mem[8'h0A] = 16'h0030;
    mem.mem[8'h32] = 16'h0020;
    fire(10'h008, 16'h00A1);
    fire(10'h004, 16'h00A2);
    fire(10'h001, 16'h00A3);
    evt_valid <= 1'b0;
    npulse += 3;
    wait_pulses;
    chk({mem.mem[8'hE1], mem.mem[8'h09]}, 32'h00A1_00A2);
    chk({mem.mem[8'h08], mem.mem[8'h31]}, 32'h8004_00A3);
    apb(1'b0, `ILU_LOG_ADDR_OFS, 0);
    chk(rd, 32'h0000_0020);
    chk(std_irq_level_out, 0);
  endtask
  task automatic t_hp;
    apb(1'b1, `ILU_CTRL_OFS, 0);
    apb(1'b1, `ILU_STD_EN_OFS, 0);
    apb(1'b1, `ILU_HP_STAT_OFS, 32'h0000_0100);
    apb(1'b1, `ILU_HP_EN_OFS, 32'h0000_0002);
    fire(10'h002, 16'h0077);
    evt_valid <= 1'b0;
    repeat (3) @(negedge pclk);
    chk({high_prio_irq, bc_hold}, 2'h3);
    apb(1'b1, `ILU_HP_STAT_OFS, 32'h0000_0001);
    @(negedge pclk);
    chk({high_prio_irq, bc_hold}, 2'h3);
    apb(1'b0, `ILU_HP_STAT_OFS, 0);
    chk(rd, 32'h0000_0002);
    apb(1'b1, `ILU_HP_STAT_OFS, 32'h0000_0002);
    @(negedge pclk);
    chk({high_prio_irq, bc_hold}, 0);
  endtask
  // main sequence: reset held six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_one;
    t_masked(10'h004);
    t_causes;
    t_masked(10'h009);
    t_burst;
    t_hp;
    end_of_test;
  end
endmodule
